//--- logic/scp_core.sv
// Slave configuration port: init, mode pick, stream load, start-up.
// Assumes pins come from another domain and are sampled on core_clk;
// the configuration clock is found by edge detection, not used as clock.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module scp_core
  import scp_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h0000_1234  // Arbitrary value
)
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Configuration inputs
  input  wire logic        program_n,
  input  wire logic        config_clock,
  input  wire logic        serial_data_in,
  input  wire logic [31:0] par_data,
  input  wire logic        chip_select_n,
  input  wire logic        write_select_n,
  input  wire logic [2:0]  mode_select,
  input  wire logic        lock_ok,
  input  wire logic        match_ok,
  // Open-drain init/error pin
  input  wire logic        init_err_n_in,
  output logic             init_err_n_out,
  output logic             init_err_n_oe,
  // Done pin
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe,
  // Status
  output logic             config_error,
  output logic             startup_end_state
);

  typedef struct packed {
    logic [SCP_NPINS-1:0]               sy1;
    logic [SCP_NPINS-1:0]               sy2;
    logic [SCP_NPINS-1:0]               sy3;
    scp_pins_s                          flt;
    logic                               config_clock_q;
    scp_state_e                         st;
    logic                               mode_par;
    logic                               bw_ok;
    logic                               lead_seen;
    logic [1:0]                         bw;
    logic [31:0]                        sr;
    logic [5:0]                         bits;
    logic [15:0]                        cnt;
    logic [3:0]                         addr;
    logic [3:0]                         clr_idx;
    logic                               crc_ok;
    logic                               err_id;
    logic                               err_crc;
    logic [2:0]                         step;
    scp_ctrl_s                          ctrl;
    logic                               ack;
    logic [31:0]                        rdata;
    logic [SCP_MEM_WORDS-1:0][31:0]     mem;
  } scp_core_s;

  scp_core_s      r;
  scp_core_s      n;
  scp_pins_s      pins_raw;
  logic           rise;
  logic           cap;
  logic [31:0]    sh;
  logic [5:0]     nb;
  logic [5:0]     bits_sum;
  logic           word_done;
  logic           su_hold;
  logic           req;
  logic [31:0]    rd_mux;
  logic [31:0]    status_word;
  scp_crc_if      crc_bus ();

  // Check sum engine
  scp_crc u_crc (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .bus      (crc_bus.engine)
  );

  // Pin bundle, same order as the struct
  assign pins_raw = {program_n, lock_ok, match_ok, mode_select, done_in,
                     init_err_n_in, write_select_n, chip_select_n,
                     par_data, serial_data_in, config_clock};

  // Link clock edge and capture qualifier
  assign rise = r.flt.config_clock & ~r.config_clock_q;
  assign cap  = rise & (~r.mode_par |
                (~r.flt.chip_select_n & ~r.flt.write_select_n));

  // Shift in per mode and width, MSB first
  assign sh = !r.mode_par ? {r.sr[30:0], r.flt.serial_data_in} :
              (r.bw == SCP_BW_X8)  ? {r.sr[23:0], r.flt.data[7:0]} :
              (r.bw == SCP_BW_X16) ? {r.sr[15:0], r.flt.data[15:0]} :
              r.flt.data;
  assign nb = !r.mode_par ? SCP_NB_1 :
              (r.bw == SCP_BW_X8)  ? SCP_NB_8 :
              (r.bw == SCP_BW_X16) ? SCP_NB_16 : SCP_NB_32;
  assign bits_sum  = r.bits + nb;
  assign word_done = cap && (bits_sum == SCP_NB_32);

  // Start-up stall: lock, match and done waits
  assign su_hold =
    (r.ctrl.lock_en && r.step == r.ctrl.lock_wait_step &&
     !r.flt.lock_ok) ||
    (r.ctrl.match_en && r.step == r.ctrl.match_wait_step &&
     !r.flt.match_ok) ||
    (r.step == r.ctrl.done_step && !r.flt.done_in);

  // Check sum feed
  assign crc_bus.clr   = (r.st == SCP_ST_INIT);
  assign crc_bus.valid = (r.st == SCP_ST_DATA) && word_done;
  assign crc_bus.word  = sh;

  // Register read mux; unmapped offsets read zero
  assign status_word = {11'h000, r.step, r.err_crc, r.err_id, r.crc_ok,
                        r.bw_ok, r.bw, r.mode_par, r.st};
  assign req    = avs_read | avs_write;
  assign rd_mux =
    (avs_address == SCP_OFS_CTRL)   ? {20'h0_0000, r.ctrl} :
    (avs_address == SCP_OFS_STATUS) ? status_word :
    (avs_address == SCP_OFS_DEVID)  ? DEVICE_ID :
    (avs_address == SCP_OFS_CRC)    ? crc_bus.value :
    (avs_address[7:6] == SCP_MEM_PAGE && avs_address[1:0] == 2'h0) ?
      r.mem[avs_address[5:2]] : 32'h0000_0000;

  // Next state: synchronisers, sequencer, register slave
  always_comb begin
    n = r;
    // Three stages; a change counts once stages two and three agree
    n.sy1 = pins_raw;
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.flt = scp_pins_s'((r.sy2 & r.sy3) | (r.flt & (r.sy2 ^ r.sy3)));
    n.config_clock_q = r.flt.config_clock;
    case (r.st)
      SCP_ST_INIT: begin
        // Clear one word per cycle and reset the stream state
        n.mem[r.clr_idx] = 32'h0000_0000;
        n.clr_idx  = r.clr_idx + 4'h1;
        n.mode_par = 1'b0;
        n.bw_ok    = 1'b0;
        n.lead_seen = 1'b0;
        n.bits     = 6'h00;
        n.sr       = 32'h0000_0000;
        n.addr     = 4'h0;
        n.crc_ok   = 1'b0;
        n.err_id   = 1'b0;
        n.err_crc  = 1'b0;
        n.step     = 3'h0;
        if (r.clr_idx == SCP_MEM_LAST) begin
          n.st = SCP_ST_WAIT;
        end
      end
      SCP_ST_WAIT: begin
        // Stay put while anyone holds the pin low
        if (r.flt.init_in) begin
          if (r.flt.mode == SCP_MODE_SERIAL) begin
            n.mode_par = 1'b0;
            n.st       = SCP_ST_SYNC;
          end else if (r.flt.mode == SCP_MODE_PAR) begin
            n.mode_par = 1'b1;
            n.st       = SCP_ST_SYNC;
          end else begin
            n.st = SCP_ST_IDLE;
          end
        end
      end
      SCP_ST_SYNC: begin
        if (cap && r.mode_par && !r.bw_ok) begin
          // Width pattern, checked right after the lead byte
          n.lead_seen = (r.flt.data[7:0] == SCP_BUSW_LEAD);
          if (r.lead_seen) begin
            if (r.flt.data == SCP_BUSW_X32) begin
              n.bw    = SCP_BW_X32;
              n.bw_ok = 1'b1;
            end else if (r.flt.data[15:0] == SCP_BUSW_X16) begin
              n.bw    = SCP_BW_X16;
              n.bw_ok = 1'b1;
            end else if (r.flt.data[7:0] == SCP_BUSW_X8) begin
              n.bw    = SCP_BW_X8;
              n.bw_ok = 1'b1;
            end
          end
        end else if (cap) begin
          n.sr = sh;
          if (sh == SCP_SYNC_WORD) begin
            n.bits = 6'h00;
            n.st   = SCP_ST_DEVID;
          end
        end
      end
      SCP_ST_DEVID, SCP_ST_CMD, SCP_ST_DATA, SCP_ST_CRCV: begin
        if (cap) begin
          n.sr   = sh;
          n.bits = word_done ? 6'h00 : bits_sum;
        end
        if (word_done) begin
          case (r.st)
            SCP_ST_DEVID: begin
              if (sh != DEVICE_ID) begin
                n.err_id = 1'b1;
                n.st     = SCP_ST_ERR;
              end else begin
                n.st = SCP_ST_CMD;
              end
            end
            SCP_ST_CMD: begin
              // Unknown opcodes and pad words pass by
              if (sh[31:24] == SCP_OP_DATA && sh[15:0] != 16'h0000) begin
                n.cnt = sh[15:0];
                n.st  = SCP_ST_DATA;
              end else if (sh[31:24] == SCP_OP_CRC) begin
                n.st = SCP_ST_CRCV;
              end else if (sh[31:24] == SCP_OP_START && r.crc_ok) begin
                n.step = 3'h0;
                n.st   = SCP_ST_STARTUP;
              end
            end
            SCP_ST_DATA: begin
              // Store wraps past the last word
              n.mem[r.addr] = sh;
              n.addr = r.addr + 4'h1;
              n.cnt  = r.cnt - 16'h0001;
              if (r.cnt == 16'h0001) begin
                n.st = SCP_ST_CMD;
              end
            end
            SCP_ST_CRCV: begin
              if (sh != crc_bus.value) begin
                n.err_crc = 1'b1;
                n.st      = SCP_ST_ERR;
              end else begin
                n.crc_ok = 1'b1;
                n.st     = SCP_ST_CMD;
              end
            end
            default: begin
              n.st = r.st;
            end
          endcase
        end
      end
      SCP_ST_STARTUP: begin
        // Trailing data is ignored; only clock edges move the steps
        if (rise && !su_hold) begin
          if (r.step == SCP_EOS_STEP) begin
            n.st = SCP_ST_EOS;
          end else begin
            n.step = r.step + 3'h1;
          end
        end
      end
      SCP_ST_EOS, SCP_ST_ERR, SCP_ST_IDLE: begin
        n.st = r.st;
      end
      default: begin
        n.st = SCP_ST_INIT;
      end
    endcase
    // Program reset overrides everything, errors included
    if (!r.flt.program_n) begin
      n.st      = SCP_ST_INIT;
      n.clr_idx = 4'h0;
    end
    // Register slave: one wait state, then the answer
    n.ack = req & ~r.ack;
    if (req && !r.ack) begin
      n.rdata = rd_mux;
    end
    if (avs_write && r.ack && avs_address == SCP_OFS_CTRL) begin
      n.ctrl = scp_ctrl_s'(avs_writedata[11:0]);
    end
  end

  // State register; power-up lands in initialization
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r      <= '0;
      r.st   <= SCP_ST_INIT;
      r.ctrl <= scp_ctrl_s'(SCP_CTRL_RST);
    end else if (clk_en) begin
      r <= n;
    end
  end

  // Pins: init low in init and error; done low until released
  assign init_err_n_out    = 1'b0;
  assign init_err_n_oe     = (r.st == SCP_ST_INIT) ||
                             (r.st == SCP_ST_ERR);
  assign done_out = (r.st == SCP_ST_EOS) ||
                    (r.st == SCP_ST_STARTUP && r.step >= r.ctrl.done_step);
  assign done_oe  = !done_out || r.ctrl.active_done_drive_option;
  assign config_error      = r.err_id | r.err_crc;
  assign startup_end_state = (r.st == SCP_ST_EOS);
  assign avs_readdata      = r.rdata;
  assign avs_waitrequest   = req & ~r.ack;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_bad_id;
    clk_en && r.st == SCP_ST_DEVID && word_done && sh != DEVICE_ID &&
    r.flt.program_n;
  endsequence
  sequence s_err_shown;
    r.st == SCP_ST_ERR && init_err_n_oe && config_error;
  endsequence

  AST_PROG_INIT: assert property (
    clk_en && !r.flt.program_n |=> r.st == SCP_ST_INIT && r.clr_idx == 4'h0)
    else $error("program reset did not restart initialization");
  AST_INIT_CLEARS: assert property (
    clk_en && r.st == SCP_ST_INIT |-> init_err_n_oe ##1
    r.mem[$past(r.clr_idx)] == 32'h0000_0000)
    else $error("initialization did not clear memory or drive pin");
  AST_WAIT_HELD: assert property (
    clk_en && r.st == SCP_ST_WAIT && !r.flt.init_in && r.flt.program_n
    |=> r.st == SCP_ST_WAIT && !init_err_n_oe)
    else $error("left init wait while pin low");
  AST_MODE_PICK: assert property (
    clk_en && r.st == SCP_ST_WAIT && r.flt.init_in && r.flt.program_n &&
    r.flt.mode == SCP_MODE_PAR |=> r.st == SCP_ST_SYNC && r.mode_par)
    else $error("parallel mode not taken");
  AST_SELECT_GATE: assert property (
    clk_en && r.st == SCP_ST_SYNC && r.mode_par && r.bw_ok &&
    r.flt.chip_select_n && r.flt.program_n |=> $stable(r.sr))
    else $error("parallel word taken without chip select");
  AST_SYNC_FOUND: assert property (
    clk_en && r.st == SCP_ST_SYNC && cap && (!r.mode_par || r.bw_ok) &&
    sh == SCP_SYNC_WORD && r.flt.program_n |=> r.st == SCP_ST_DEVID)
    else $error("sync word missed");
  AST_BAD_ID: assert property (
    s_bad_id |=> s_err_shown)
    else $error("identifier mismatch not flagged");
  AST_BAD_CRC: assert property (
    clk_en && r.st == SCP_ST_CRCV && word_done && r.flt.program_n &&
    sh != crc_bus.value |=> s_err_shown)
    else $error("check sum mismatch not flagged");
  AST_ERR_STICKS: assert property (
    s_err_shown ##0 r.flt.program_n |=> r.st == SCP_ST_ERR && config_error)
    else $error("error state left without program reset");
  AST_START_NEEDS_CRC: assert property (
    $rose(r.st == SCP_ST_STARTUP) |-> $past(r.crc_ok) && r.step == 3'h0)
    else $error("start-up without passed check sum");
  AST_DONE_PAUSE: assert property (
    clk_en && r.st == SCP_ST_STARTUP && r.step == r.ctrl.done_step &&
    !r.flt.done_in && r.flt.program_n |=> $stable(r.step) &&
    r.st == SCP_ST_STARTUP && done_out)
    else $error("start-up passed done step while pin low");

endmodule

//--- logic/scp_crc.sv
// Running check sum over loaded configuration words.
// Assumes one word per enabled cycle at most; clear wins over a word.
`timescale 1ns/10ps
module scp_crc
  import scp_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  // Word path
  scp_crc_if.engine bus
);

  typedef struct packed {
    logic [31:0] crc;
  } scp_crc_s;

  scp_crc_s r;
  scp_crc_s n;

  // One word per step, MSB first
  function automatic logic [31:0] scp_crc_step(input logic [31:0] c,
                                               input logic [31:0] w);
    logic [31:0] x;
    x = c;
    for (int i = 31; i >= 0; i--) begin
      x = {x[30:0], 1'b0} ^ ((x[31] ^ w[i]) ? SCP_CRC_POLY : 32'h0000_0000);
    end
    return x;
  endfunction

  // Next value
  always_comb begin
    n = r;
    if (bus.clr) begin
      n.crc = SCP_CRC_SEED;
    end else if (bus.valid) begin
      n.crc = scp_crc_step(r.crc, bus.word);
    end
  end

  // State register, frozen while clk_en is low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r.crc <= SCP_CRC_SEED;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign bus.value = r.crc;

endmodule

//--- logic/scp_crc_if.sv
// Word path between the sequencer and its check sum engine.
// Both ends sit on core_clk; no crossing inside.
`timescale 1ns/10ps
interface scp_crc_if;
  logic        clr;
  logic        valid;
  logic [31:0] word;
  logic [31:0] value;
  modport user   (output clr, output valid, output word, input value);
  modport engine (input clr, input valid, input word, output value);
endinterface

//--- logic/scp_pkg.sv
// Constants and types shared by the slave configuration port files.
// Assumes a 40 MHz core clock and pins from outside that clock's domain.
package scp_pkg;

  // Stream signatures
  localparam logic [31:0] SCP_SYNC_WORD = 32'hAA99_5566;
  localparam logic [7:0]  SCP_BUSW_LEAD = 8'hBB;
  localparam logic [7:0]  SCP_BUSW_X8   = 8'h11;
  localparam logic [15:0] SCP_BUSW_X16  = 16'h1122;
  localparam logic [31:0] SCP_BUSW_X32  = 32'h1122_0044;

  // Bus width codes and bits per capture
  localparam logic [1:0] SCP_BW_X8  = 2'h0;
  localparam logic [1:0] SCP_BW_X16 = 2'h1;
  localparam logic [1:0] SCP_BW_X32 = 2'h2;
  localparam logic [5:0] SCP_NB_1   = 6'h01;
  localparam logic [5:0] SCP_NB_8   = 6'h08;
  localparam logic [5:0] SCP_NB_16  = 6'h10;
  localparam logic [5:0] SCP_NB_32  = 6'h20;

  // Mode pin patterns
  localparam logic [2:0] SCP_MODE_SERIAL = 3'h7;
  localparam logic [2:0] SCP_MODE_PAR    = 3'h6;

  // Command opcodes, top byte of a command word
  localparam logic [7:0] SCP_OP_DATA  = 8'h01;
  localparam logic [7:0] SCP_OP_CRC   = 8'h02;
  localparam logic [7:0] SCP_OP_START = 8'h03;

  // Check sum and configuration store
  localparam logic [31:0] SCP_CRC_POLY  = 32'h04C1_1DB7;
  localparam logic [31:0] SCP_CRC_SEED  = 32'hFFFF_FFFF;
  localparam int          SCP_MEM_WORDS = 16;
  localparam logic [3:0]  SCP_MEM_LAST  = 4'hF;
  localparam logic [2:0]  SCP_EOS_STEP  = 3'h7;

  // Register offsets (byte addresses) and reset value
  localparam logic [7:0]  SCP_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  SCP_OFS_STATUS = 8'h04;
  localparam logic [7:0]  SCP_OFS_DEVID  = 8'h08;
  localparam logic [7:0]  SCP_OFS_CRC    = 8'h0C;
  localparam logic [1:0]  SCP_MEM_PAGE   = 2'h1;
  localparam logic [11:0] SCP_CTRL_RST   = 12'h003;

  // Main sequencer states
  typedef enum logic [10:0] {
    SCP_ST_INIT    = 11'h001,
    SCP_ST_WAIT    = 11'h002,
    SCP_ST_SYNC    = 11'h004,
    SCP_ST_DEVID   = 11'h008,
    SCP_ST_CMD     = 11'h010,
    SCP_ST_DATA    = 11'h020,
    SCP_ST_CRCV    = 11'h040,
    SCP_ST_STARTUP = 11'h080,
    SCP_ST_EOS     = 11'h100,
    SCP_ST_ERR     = 11'h200,
    SCP_ST_IDLE    = 11'h400
  } scp_state_e;

  // Control register layout
  typedef struct packed {
    logic       active_done_drive_option;
    logic       match_en;
    logic [2:0] match_wait_step;
    logic       lock_en;
    logic [2:0] lock_wait_step;
    logic [2:0] done_step;
  } scp_ctrl_s;

  // Pin bundle, synchronised as one vector
  typedef struct packed {
    logic        program_n;
    logic        lock_ok;
    logic        match_ok;
    logic [2:0]  mode;
    logic        done_in;
    logic        init_in;
    logic        write_select_n;
    logic        chip_select_n;
    logic [31:0] data;
    logic        serial_data_in;
    logic        config_clock;
  } scp_pins_s;

  localparam int SCP_NPINS = $bits(scp_pins_s);

endpackage

//--- testbench/scp_host.sv
// Host model: drives the configuration pins and the pull-ups.
// Assumes the bench sets bus width and hold flags by hierarchy.
`timescale 1ns/10ps
module scp_host (
  // Clock
  input  wire logic   core_clk,
  // Pin enables from the device
  input  wire logic   init_err_n_oe,
  input  wire logic   done_out,
  input  wire logic   done_oe,
  // Host-driven pins and resolved wires
  output logic        config_clock,
  output logic        serial_data_in,
  output logic [31:0] par_data,
  output logic        chip_select_n,
  output logic        write_select_n,
  output logic        init_w,
  output logic        done_w
);
  logic init_hold = 1'b0;
  logic done_hold = 1'b0;
  int   nb = 1;
  // Pull-ups; an outside party may hold either line low
  assign init_w = ~init_err_n_oe & ~init_hold;
  assign done_w = (done_oe ? done_out : 1'b1) & ~done_hold;
  // Clock stands low outside frames
  initial begin
    config_clock = 1'b0;
    serial_data_in = 1'b1;
    par_data = 32'hFFFF_FFFF;
    chip_select_n = 1'b1;
    write_select_n = 1'b1;
  end
  // One capture; data held four core cycles each side of the rise
  task automatic pulse(input logic [31:0] d);
    par_data <= d;
    serial_data_in <= d[0];
    repeat (4) @(posedge core_clk);
    config_clock <= 1'b1;
    repeat (4) @(posedge core_clk);
    config_clock <= 1'b0;
  endtask
  // Whole word, earlier capture carries upper bits
  task automatic word(input logic [31:0] w);
    for (int i = 32 - nb; i >= 0; i -= nb) begin
      pulse(w >> i);
    end
  endtask
endmodule

//--- testbench/slave_config_port_tb.sv
// Self-checking bench for scp_core: serial and parallel loads, errors.
// Assumes scp_host stands for the configuration host.
`timescale 1ns/10ps
module slave_config_port_tb;
  import scp_pkg::*;
  localparam logic [31:0] DEV_ID = 32'h0000_5A3C; // Arbitrary value
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        program_n = 1'b1;
  logic [2:0]  mode_select = SCP_MODE_SERIAL;
  logic        lock_ok = 1'b1;
  logic        config_clock, serial_data_in, chip_select_n, write_select_n;
  logic [31:0] par_data, d0, d1, crc, rd_d;
  logic        init_w, init_err_n_out, init_err_n_oe, rd_v = 1'b0;
  logic        done_w, done_out, done_oe, config_error, startup_end_state;
  logic [63:0] q[$];
  logic [31:0] st[$];
  int          n_fail = 0;
  int          comparisons = 0;

  always #12.5 core_clk = ~core_clk;

  scp_core #(.DEVICE_ID(DEV_ID)) u_dut (.core_clk, .arst_n, .clk_en(1'b1),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .program_n, .config_clock, .serial_data_in,
    .par_data, .chip_select_n, .write_select_n, .mode_select, .lock_ok,
    .match_ok(1'b1), .init_err_n_in(init_w), .init_err_n_out,
    .init_err_n_oe, .done_in(done_w), .done_out, .done_oe, .config_error,
    .startup_end_state);
  scp_host u_host (.core_clk, .init_err_n_oe, .done_out, .done_oe,
    .config_clock, .serial_data_in, .par_data, .chip_select_n,
    .write_select_n, .init_w, .done_w);

  // Oldest note against each observed value
  always @(posedge core_clk) begin
    if (rd_v) begin
      comparisons++;
      if ((rd_d & q[0][31:0]) !== q[0][63:32]) begin
        n_fail++;
        $display("ERROR %0t: got %h want %h", $time, rd_d, q[0][63:32]);
      end
      void'(q.pop_front());
    end
  end

  task automatic look(input logic [31:0] v, e, m);
    q.push_back({e, m});
    rd_d <= v;
    rd_v <= 1'b1;
    @(posedge core_clk);
    rd_v <= 1'b0;
    @(posedge core_clk);
  endtask
  // Order: error, end state, init drive, done wire
  task automatic pins(input logic [3:0] e);
    // State moves one edge after the last captured clock rise
    repeat (2) @(posedge core_clk);
    look({28'h0, config_error, startup_end_state, init_err_n_oe, done_w},
         {28'h0, e}, 32'h0000_000F);
  endtask
  // Avalon access; held until waitrequest samples low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, e = 0, m = 0);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!w) look(avs_readdata, e, m);
    else @(posedge core_clk);
  endtask
  task automatic load();
    foreach (st[i]) u_host.word(st[i]);
  endtask
  task automatic ones(input int n);
    repeat (n) u_host.pulse(32'hFFFF_FFFF);
  endtask
  // Program pulse; mode is set before init can rise
  task automatic reprogram(input logic [2:0] md, input int bits);
    mode_select <= md;
    u_host.nb = bits;
    u_host.chip_select_n <= (md != SCP_MODE_PAR);
    u_host.write_select_n <= (md != SCP_MODE_PAR);
    program_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    pins(4'b0010);
    program_n <= 1'b1;
    repeat (40) @(posedge core_clk);
  endtask
  function automatic logic [31:0] crc_of(input logic [31:0] a, b);
    logic [31:0] c;
    logic [63:0] w;
    c = SCP_CRC_SEED;
    w = {a, b};
    for (int i = 63; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? SCP_CRC_POLY : 32'h0000_0000);
    end
    return c;
  endfunction
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(87));
    d0 = $urandom();
    d1 = $urandom();
    crc = crc_of(d0, d1);
    u_host.init_hold = 1'b1;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (60) @(posedge core_clk);
    bus(0, SCP_OFS_STATUS, 0, 32'h0000_0002, 32'h0000_07FF);
    pins(4'b0000);
    bus(0, SCP_OFS_CTRL, 0, 32'h0000_0003, '1);
    bus(0, SCP_OFS_DEVID, 0, DEV_ID, '1);
    bus(0, 8'h20, 0, 32'h0000_0000, '1);
    bus(1, SCP_OFS_CTRL, 32'h0000_004B); // Lock wait at step 1, done at 3
    bus(0, SCP_OFS_CTRL, 0, 32'h0000_004B, '1);
    u_host.init_hold <= 1'b0;
    lock_ok <= 1'b0;
    repeat (10) @(posedge core_clk);
    st = {32'hFFFF_FFFF, SCP_SYNC_WORD, DEV_ID, 32'h0100_0002, d0, d1,
          32'h0200_0000, crc, 32'h0300_0000};
    load();
    ones(12);
    bus(0, SCP_OFS_STATUS, 0, 32'h0004_0080, 32'h001C_07FF);
    pins(4'b0000);
    lock_ok <= 1'b1;
    u_host.done_hold <= 1'b1;
    ones(12);
    bus(0, SCP_OFS_STATUS, 0, 32'h000C_0080, 32'h001C_07FF);
    bus(0, SCP_OFS_CRC, 0, crc, '1);
    bus(0, 8'h40, 0, d0, '1);
    bus(0, 8'h44, 0, d1, '1);
    u_host.done_hold <= 1'b0;
    for (int k = 0; k < 40 && done_w !== 1'b1; k++) begin
      ones(1);
    end
    ones(8);
    pins(4'b0101);
    bus(0, SCP_OFS_STATUS, 0, 32'h0000_0100, 32'h0000_07FF);
    // Parallel x32, one word without chip select, one without write select, wrong check sum
    reprogram(SCP_MODE_PAR, 32);
    bus(0, 8'h40, 0, 32'h0000_0000, '1);
    u_host.pulse({24'h0, SCP_BUSW_LEAD});
    u_host.pulse(SCP_BUSW_X32);
    // A stray sync word would derail the load if it were taken
    u_host.chip_select_n <= 1'b1;
    u_host.pulse(SCP_SYNC_WORD);
    u_host.chip_select_n <= 1'b0;
    u_host.write_select_n <= 1'b1;
    u_host.pulse(SCP_SYNC_WORD);
    u_host.write_select_n <= 1'b0;
    st[7] = ~crc;
    st.delete(8);
    load();
    pins(4'b1010);
    bus(0, SCP_OFS_STATUS, 0, 32'h0002_6A00, 32'h0002_7FFF);
    u_host.word(SCP_SYNC_WORD);
    pins(4'b1010);
    // Parallel x8, wrong identifier
    reprogram(SCP_MODE_PAR, 8);
    u_host.pulse({24'h0, SCP_BUSW_LEAD});
    u_host.pulse({24'h0, SCP_BUSW_X8});
    st = {32'hFFFF_FFFF, SCP_SYNC_WORD, ~DEV_ID};
    load();
    pins(4'b1010);
    bus(0, SCP_OFS_STATUS, 0, 32'h0001_4A00, 32'h0001_7FFF);
    give_verdict();
  end
endmodule
